// >>> irq_ctrl_defs.vh
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_ENABLE 8'h00
`define OFS_PRIORITY 8'h04
`define OFS_EXT_TYPE 8'h08
`define OFS_REQ_FLAGS 8'h0C
`define OFS_SERVICE 8'h10
`define OFS_EVT_STATUS 8'h14
`define OFS_EVT_CLEAR 8'h18
`define OFS_EVT_ENABLE 8'h1C

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define NUM_SRC 5
`define GLOBAL_EN_BIT 7
`define SRC_EXT0 0
`define SRC_TMR0 1
`define SRC_EXT1 2
`define SRC_TMR1 3
`define SRC_SER 4
`define EVT_START_BIT 0
`define EVT_NEST_BIT 1
`define EVT_BAD_RET_BIT 2
`define NUM_EVT 3
`define RST_ENABLE 8'h00
`define RST_PRIORITY 5'h00
`define RST_EXT_TYPE 2'h0

// ----------------------------------------
// Vectors
// ----------------------------------------
`define VEC_EXT0 8'h03
`define VEC_TMR0 8'h0B
`define VEC_EXT1 8'h13
`define VEC_TMR1 8'h1B
`define VEC_SER 8'h23

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define RESP_MIN_NS 2000
`define RESP_MAX_NS 5250
`define RESP_MIN_CYC ((`RESP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_MAX_CYC (`RESP_MAX_NS / `CLK_PERIOD_NS)

`endif

// >>> ext_req_detect.v
`timescale 1ns/1ps
`default_nettype none
module ext_req_detect (
	// Clock and reset
	input wire clk_i,
	input wire rst_b_i,
	input wire ce_i,
	// Pin and control
	input wire pin_i,
	input wire edge_sel_i,
	input wire hw_clear_i,
	input wire sw_write_i,
	input wire sw_value_i,
	// Request
	output wire flag_o
);

reg sync1_reg;
reg sync2_reg;
reg prev_reg;
reg edge_flag_reg;
reg edge_flag_next;
wire fall;

assign fall = prev_reg & ~sync2_reg;

always @(posedge clk_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		sync1_reg <= 1'b1;
		sync2_reg <= 1'b1;
		prev_reg <= 1'b1;
		edge_flag_reg <= 1'b0;
	end else if (ce_i) begin
		sync1_reg <= pin_i;
		sync2_reg <= sync1_reg;
		prev_reg <= sync2_reg;
		edge_flag_reg <= edge_flag_next;
	end
end

// Hardware edge wins over a clear in the same cycle
always @* begin
	edge_flag_next = edge_flag_reg;
	if (hw_clear_i)
		edge_flag_next = 1'b0;
	if (sw_write_i)
		edge_flag_next = sw_value_i;
	if (edge_sel_i && fall)
		edge_flag_next = 1'b1;
end

// Level mode follows the synchronised pin while low
assign flag_o = edge_sel_i ? edge_flag_reg : ~sync2_reg;

endmodule
`default_nettype wire

// >>> prio_pick.v
`timescale 1ns/1ps
`default_nettype none
module prio_pick #(
	parameter N = 5
) (
	// Requests, index 0 is strongest
	input wire [N-1:0] req_i,
	// Winner
	output reg valid_o,
	output reg [2:0] idx_o
);

integer i;

always @* begin
	valid_o = 1'b0;
	idx_o = 3'h0;
	for (i = N - 1; i >= 0; i = i - 1) begin
		if (req_i[i]) begin
			valid_o = 1'b1;
			idx_o = i[2:0];
		end
	end
end

endmodule
`default_nettype wire

// >>> irq_ctrl.v
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
module irq_ctrl (
	// Clock and reset
	input wire clk_i,
	input wire rst_b_i,
	input wire ce_i,
	// AHB-Lite slave
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output wire [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	// Request sources
	input wire ext_req0_pin_i,
	input wire ext_req1_pin_i,
	input wire timer0_overflow_i,
	input wire timer1_overflow_i,
	input wire serial_rx_tx_flags_i,
	// Core side
	input wire return_from_service_i,
	output wire service_start_o,
	output wire [7:0] service_vector_o,
	output wire [1:0] level_active_o,
	// Event interrupt
	output wire irq_o
);

localparam integer RESP_MIN_N = `RESP_MIN_CYC;
localparam [5:0] RESP_MIN = RESP_MIN_N[5:0];
localparam [1:0] S_IDLE = 2'b01;
localparam [1:0] S_WAIT = 2'b10;

// ----------------------------------------
// Vector lookup
// ----------------------------------------
function [7:0] vector_of;
	input [2:0] idx;
	begin
		case (idx)
			3'h0: vector_of = `VEC_EXT0;
			3'h1: vector_of = `VEC_TMR0;
			3'h2: vector_of = `VEC_EXT1;
			3'h3: vector_of = `VEC_TMR1;
			default: vector_of = `VEC_SER;
		endcase
	end
endfunction

// ----------------------------------------
// Storage
// ----------------------------------------
reg [7:0] enable_reg;
reg [4:0] priority_reg;
reg [1:0] ext_type_reg;
reg [1:0] tmr_flag_reg;
reg [1:0] tmr_flag_next;
reg [1:0] active_reg;
reg [1:0] active_next;
reg [2:0] evt_status_reg;
reg [2:0] evt_status_next;
reg [2:0] evt_enable_reg;
reg [1:0] state_reg;
reg [1:0] state_next;
reg [5:0] wait_cnt_reg;
reg [5:0] wait_cnt_next;
reg [2:0] cand_reg;
reg [2:0] serv_idx_reg;
reg [7:0] vector_reg;
reg start_reg;
reg start_next;
reg irq_reg;
reg [31:0] hrdata_reg;
reg hready_reg;
reg dp_write_reg;
reg [7:0] dp_addr_reg;

wire [4:0] req_flags;
wire [4:0] eligible;
wire [4:0] high_req;
wire [4:0] low_req;
wire high_valid;
wire low_valid;
wire [2:0] high_idx;
wire [2:0] low_idx;
reg win_valid;
reg [2:0] win_idx;
reg win_high;
wire [1:0] ext_flag;
wire [1:0] ext_pin;
reg [1:0] ext_clear;
wire addr_phase;
wire wr_flags;
wire [31:0] service_word;
reg [31:0] rd_word;

assign ext_pin = {ext_req1_pin_i, ext_req0_pin_i};

// ----------------------------------------
// External request inputs
// ----------------------------------------
genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : ext
		ext_req_detect u_det (
			.clk_i(clk_i),
			.rst_b_i(rst_b_i),
			.ce_i(ce_i),
			.pin_i(ext_pin[g]),
			.edge_sel_i(ext_type_reg[g]),
			.hw_clear_i(ext_clear[g]),
			.sw_write_i(wr_flags),
			.sw_value_i(hwdata_i[2*g]),
			.flag_o(ext_flag[g])
		);
	end
endgenerate

// Poll order: ext0, timer0, ext1, timer1, serial
assign req_flags = {serial_rx_tx_flags_i, tmr_flag_reg[1], ext_flag[1],
	tmr_flag_reg[0], ext_flag[0]};

// ----------------------------------------
// Arbitration
// ----------------------------------------
assign eligible = req_flags & enable_reg[4:0]
	& {5{enable_reg[`GLOBAL_EN_BIT]}};
assign high_req = eligible & priority_reg;
assign low_req = eligible & ~priority_reg;

prio_pick #(
	.N(`NUM_SRC)
) u_pick_high (
	.req_i(high_req),
	.valid_o(high_valid),
	.idx_o(high_idx)
);

prio_pick #(
	.N(`NUM_SRC)
) u_pick_low (
	.req_i(low_req),
	.valid_o(low_valid),
	.idx_o(low_idx)
);

// High nests over low; nothing preempts its own or a higher level
always @* begin
	win_valid = 1'b0;
	win_idx = 3'h0;
	win_high = 1'b0;
	if (high_valid && !active_reg[1]) begin
		win_valid = 1'b1;
		win_idx = high_idx;
		win_high = 1'b1;
	end else if (low_valid && active_reg == 2'b00) begin
		win_valid = 1'b1;
		win_idx = low_idx;
	end
end

// ----------------------------------------
// Response timing and service tracking
// ----------------------------------------
always @* begin
	state_next = state_reg;
	wait_cnt_next = wait_cnt_reg;
	start_next = 1'b0;
	case (state_reg)
		S_IDLE: begin
			wait_cnt_next = 6'h01;
			if (win_valid)
				state_next = S_WAIT;
		end
		S_WAIT: begin
			if (!win_valid) begin
				state_next = S_IDLE;
			end else if (win_idx != cand_reg) begin
				wait_cnt_next = 6'h01;
			end else if (wait_cnt_reg >= RESP_MIN - 6'h01) begin
				start_next = 1'b1;
				state_next = S_IDLE;
			end else begin
				wait_cnt_next = wait_cnt_reg + 6'h01;
			end
		end
		default: begin
			state_next = S_IDLE;
		end
	endcase
end

// Starting service clears the edge and timer flags of that source
always @* begin
	ext_clear[0] = start_next && win_idx == `SRC_EXT0;
	ext_clear[1] = start_next && win_idx == `SRC_EXT1;
	tmr_flag_next = tmr_flag_reg;
	if (start_next && win_idx == `SRC_TMR0)
		tmr_flag_next[0] = 1'b0;
	if (start_next && win_idx == `SRC_TMR1)
		tmr_flag_next[1] = 1'b0;
	if (wr_flags)
		tmr_flag_next = {hwdata_i[`SRC_TMR1], hwdata_i[`SRC_TMR0]};
	if (timer0_overflow_i)
		tmr_flag_next[0] = 1'b1;
	if (timer1_overflow_i)
		tmr_flag_next[1] = 1'b1;
end

always @* begin
	active_next = active_reg;
	evt_status_next = evt_status_reg;
	// A new event in the clearing cycle stays set
	if (dp_write_reg && dp_addr_reg == `OFS_EVT_CLEAR)
		evt_status_next = evt_status_reg & ~hwdata_i[2:0];
	if (return_from_service_i) begin
		if (active_reg[1])
			active_next[1] = 1'b0;
		else if (active_reg[0])
			active_next[0] = 1'b0;
		else
			evt_status_next[`EVT_BAD_RET_BIT] = 1'b1;
	end
	if (start_next) begin
		if (win_high)
			active_next[1] = 1'b1;
		else
			active_next[0] = 1'b1;
		evt_status_next[`EVT_START_BIT] = 1'b1;
		if (win_high && active_reg[0])
			evt_status_next[`EVT_NEST_BIT] = 1'b1;
	end
end

// ----------------------------------------
// AHB-Lite slave
// ----------------------------------------
assign addr_phase = hsel_i && hready_i && htrans_i[1];
assign wr_flags = dp_write_reg && dp_addr_reg == `OFS_REQ_FLAGS;
assign service_word = {8'h00, vector_reg, 5'h00, serv_idx_reg, 6'h00, active_reg};

always @* begin
	rd_word = 32'h0000_0000;
	case (haddr_i[7:0])
		`OFS_ENABLE: rd_word = {24'h000000, enable_reg[7], 2'h0, enable_reg[4:0]};
		`OFS_PRIORITY: rd_word = {27'h0000000, priority_reg};
		`OFS_EXT_TYPE: rd_word = {30'h00000000, ext_type_reg};
		`OFS_REQ_FLAGS: rd_word = {27'h0000000, req_flags};
		`OFS_SERVICE: rd_word = service_word;
		`OFS_EVT_STATUS: rd_word = {29'h00000000, evt_status_reg};
		`OFS_EVT_ENABLE: rd_word = {29'h00000000, evt_enable_reg};
		default: rd_word = 32'h0000_0000;
	endcase
end

always @(posedge clk_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		enable_reg <= `RST_ENABLE;
		priority_reg <= `RST_PRIORITY;
		ext_type_reg <= `RST_EXT_TYPE;
		evt_enable_reg <= 3'h0;
		dp_write_reg <= 1'b0;
		dp_addr_reg <= 8'h00;
		hrdata_reg <= 32'h0000_0000;
		hready_reg <= 1'b1;
	end else if (ce_i) begin
		hready_reg <= 1'b1;
		dp_write_reg <= addr_phase && hwrite_i;
		if (addr_phase)
			dp_addr_reg <= haddr_i[7:0];
		if (addr_phase && !hwrite_i)
			hrdata_reg <= rd_word;
		if (dp_write_reg) begin
			case (dp_addr_reg)
				`OFS_ENABLE: enable_reg <= {hwdata_i[7], 2'h0, hwdata_i[4:0]};
				`OFS_PRIORITY: priority_reg <= hwdata_i[4:0];
				`OFS_EXT_TYPE: ext_type_reg <= hwdata_i[1:0];
				`OFS_EVT_ENABLE: evt_enable_reg <= hwdata_i[2:0];
				default: ;
			endcase
		end
	end
end

// ----------------------------------------
// Core state
// ----------------------------------------
always @(posedge clk_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		state_reg <= S_IDLE;
		wait_cnt_reg <= 6'h01;
		cand_reg <= 3'h0;
		serv_idx_reg <= 3'h0;
		vector_reg <= 8'h00;
		start_reg <= 1'b0;
		tmr_flag_reg <= 2'h0;
		active_reg <= 2'h0;
		evt_status_reg <= 3'h0;
		irq_reg <= 1'b0;
	end else if (ce_i) begin
		state_reg <= state_next;
		wait_cnt_reg <= wait_cnt_next;
		cand_reg <= win_idx;
		start_reg <= start_next;
		if (start_next) begin
			serv_idx_reg <= win_idx;
			vector_reg <= vector_of(win_idx);
		end
		tmr_flag_reg <= tmr_flag_next;
		active_reg <= active_next;
		evt_status_reg <= evt_status_next;
		irq_reg <= |(evt_status_next & evt_enable_reg);
	end
end

assign hrdata_o = hrdata_reg;
assign hreadyout_o = hready_reg;
assign hresp_o = 1'b0;
assign service_start_o = start_reg;
assign service_vector_o = vector_reg;
assign level_active_o = active_reg;
assign irq_o = irq_reg;

endmodule
`default_nettype wire

// >>> irq_ctrl_ports_note_end.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> irq_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Core side
	input wire logic return_from_service_i,
	input wire logic service_start_o,
	input wire logic [7:0] service_vector_o,
	input wire logic [1:0] level_active_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_vec;
		service_start_o |-> service_vector_o inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23};
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_hold;
		!service_start_o |-> $stable(service_vector_o);
	endproperty
	a_hold: assert property (p_hold) else $error("vector moved");
	property p_gap;
		service_start_o |=> !service_start_o [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("starts too close");
	property p_lvl;
		service_start_o |-> level_active_o != 2'h0;
	endproperty
	a_lvl: assert property (p_lvl) else $error("no level active");
	property p_nest;
		service_start_o |-> !$past(level_active_o[1]);
	endproperty
	a_nest: assert property (p_nest) else $error("high preempted");
	property p_low;
		service_start_o && $past(level_active_o[0]) |-> level_active_o[1];
	endproperty
	a_low: assert property (p_low) else $error("low preempted");
	property p_ret_hi;
		return_from_service_i && level_active_o == 2'h3 |=> level_active_o == 2'h1;
	endproperty
	a_ret_hi: assert property (p_ret_hi) else $error("bad high return");
	property p_ret_lo;
		return_from_service_i && level_active_o == 2'h1 |=> !level_active_o || service_start_o;
	endproperty
	a_ret_lo: assert property (p_ret_lo) else $error("bad low return");
	c_nest: cover property (service_start_o && level_active_o == 2'h3);
	c_ret: cover property (return_from_service_i && level_active_o == 2'h1);
	c_start: cover property (service_start_o);
endmodule
bind irq_ctrl irq_ctrl_asserts u_chk (
	.clk_i(clk_i),
	.rst_b_i(rst_b_i),
	.return_from_service_i(return_from_service_i),
	.service_start_o(service_start_o),
	.service_vector_o(service_vector_o),
	.level_active_o(level_active_o)
);
`default_nettype wire

// >>> core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Controller side
	input wire logic start_i,
	input wire logic en_i,
	input wire logic [7:0] dly_i,
	output logic ret_o
);
	logic [3:0] depth_reg;
	logic [7:0] cnt_reg;
	logic fire;
	// One return per start, innermost first, at least dly_i + 1 cycles apart
	assign fire = en_i && depth_reg != 4'h0 && cnt_reg >= dly_i && !ret_o && !start_i;
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			depth_reg <= 4'h0;
			cnt_reg <= 8'h00;
			ret_o <= 1'b0;
		end else begin
			ret_o <= fire;
			if (start_i)
				depth_reg <= depth_reg + 4'h1;
			else if (fire)
				depth_reg <= depth_reg - 4'h1;
			if (start_i || fire)
				cnt_reg <= 8'h00;
			else if (cnt_reg != 8'hFF)
				cnt_reg <= cnt_reg + 8'h01;
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h1729;
	logic hwrite = 1'b0, p0 = 1'b1, p1 = 1'b1, tm0 = 1'b0, tm1 = 1'b0, ser = 1'b0;
	logic en_m = 1'b0, ret, start, rdy, irq, hresp, ce = 1'b1, hsel = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [7:0] vec, dly_m = 8'h20;
	logic [1:0] lvl;
	int n_fail = 0, comparisons = 0, cyc = 0;
	time t_st, t0;
	logic [7:0] q[$];

	always #50 clk_i = ~clk_i;

	irq_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy),
		.hresp_o(hresp), .ext_req0_pin_i(p0), .ext_req1_pin_i(p1), .timer0_overflow_i(tm0),
		.timer1_overflow_i(tm1), .serial_rx_tx_flags_i(ser), .return_from_service_i(ret),
		.service_start_o(start), .service_vector_o(vec), .level_active_o(lvl),
		.irq_o(irq));
	core_model u_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start), .en_i(en_m),
		.dly_i(dly_m), .ret_o(ret));

	// ---
	// Checking and closing
	// ---
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic close_out;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	function automatic logic [4:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[4:0];
	endfunction
	// Start monitor takes the oldest expected vector
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			close_out;
		end
		if (ret === 1'b1)
			dly_m <= 8'h19 + {3'h0, xs()};
		if (start === 1'b1) begin
			t_st = $time - 100;
			if (q.size() != 0)
				chk({24'h0, vec}, {24'h0, q.pop_front()});
			else
				chk({24'h0, vec}, 32'hFFFFFFFF);
		end
	end

	// ---
	// Bus and helpers
	// ---
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hsel <= 1'b1;
		hsize <= 3'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_i); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk_i); while (rdy !== 1'b1);
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(hrdata, e);
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wait_q;
		int i;
		i = 0;
		while (q.size() != 0 && i < 600) begin
			@(posedge clk_i);
			i++;
		end
		chk(q.size(), 32'h0);
	endtask
	task automatic done(input int n);
		$display("test %0d finished", n);
	endtask

	initial begin
		cyc_n(8);
		rst_b_i <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h20, 32'h0);
		done(1);
		en_m <= 1'b1;
		wr(8'h08, 32'h3);
		wr(8'h00, 32'h9F);
		q = '{8'h03, 8'h0B, 8'h13, 8'h1B};
		wr(8'h0C, 32'h7);
		tm1 <= 1'b1;
		cyc_n(1);
		tm1 <= 1'b0;
		wait_q;
		done(2);
		wr(8'h00, 32'h1F);
		wr(8'h0C, 32'h2);
		cyc_n(60);
		q.push_back(8'h0B);
		wr(8'h00, 32'h9F);
		wait_q;
		wr(8'h00, 32'h9D);
		tm0 <= 1'b1;
		cyc_n(1);
		tm0 <= 1'b0;
		cyc_n(60);
		q.push_back(8'h0B);
		wr(8'h00, 32'h9F);
		wait_q;
		cyc_n(100);
		q.push_back(8'h0B);
		tm0 <= 1'b1;
		cyc_n(1);
		t0 = $time;
		tm0 <= 1'b0;
		wait_q;
		chk((t_st - t0) / 100 >= 20 && (t_st - t0) / 100 <= 52, 32'h1);
		done(3);
		cyc_n(100);
		en_m <= 1'b0;
		wr(8'h08, 32'h1);
		wr(8'h04, 32'h10);
		q.push_back(8'h03);
		p0 <= 1'b0;
		wait_q;
		q.push_back(8'h23);
		ser <= 1'b1;
		wait_q;
		chk({30'h0, lvl}, 32'h3);
		ser <= 1'b0;
		p1 <= 1'b0;
		cyc_n(60);
		q.push_back(8'h13);
		en_m <= 1'b1;
		wait_q;
		p0 <= 1'b1;
		p1 <= 1'b1;
		cyc_n(100);
		chk({30'h0, lvl}, 32'h0);
		rd(8'h10, 32'h0013_0200);
		done(4);
		wr(8'h1C, 32'h1);
		cyc_n(3);
		chk({31'h0, irq}, 32'h1);
		rd(8'h14, 32'h3);
		wr(8'h1C, 32'h0);
		cyc_n(3);
		chk({31'h0, irq}, 32'h0);
		wr(8'h1C, 32'h1);
		wr(8'h18, 32'h7);
		cyc_n(3);
		chk({31'h0, irq}, 32'h0);
		rd(8'h14, 32'h0);
		done(5);
		// Clock enable low freezes a pending request
		wr(8'h0C, 32'h2);
		ce <= 1'b0;
		cyc_n(40);
		q.push_back(8'h0B);
		ce <= 1'b1;
		wait_q;
		done(6);
		close_out;
	end
endmodule
`default_nettype wire
